// >>> hw/ptm_pkg.sv
// Purpose: Shared constants and types for the pulse measure timer channel
// Assumes: One core clock domain, all inputs synchronous to it
// Notes: Select encodings are the values driven on the config ports
package ptm_pkg;

	localparam int CNT_W = 16;

	localparam logic [15:0] CNT_ZERO  = 16'h0000;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [15:0] CNT_MAX   = 16'hffff;
	localparam logic [15:0] RST_CNT   = 16'h0000;
	localparam logic [15:0] RST_RELOAD = 16'h0000;
	localparam logic        RST_OVF   = 1'b1;
	localparam logic        RST_START = 1'b0;

	// Operating mode select
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_EVENT = 2'h1;
	localparam logic [1:0] MODE_MEAS  = 2'h2;

	// Internal count source select
	localparam logic [1:0] SRC_DIV1  = 2'h0;
	localparam logic [1:0] SRC_DIV8  = 2'h1;
	localparam logic [1:0] SRC_DIV32 = 2'h2;
	localparam logic [1:0] SRC_SUB32 = 2'h3;

	// Event source select
	localparam logic [1:0] EVT_FALL  = 2'h0;
	localparam logic [1:0] EVT_RISE  = 2'h1;
	localparam logic [1:0] EVT_BOTH  = 2'h2;
	localparam logic [1:0] EVT_NEIGH = 2'h3;

	// Measurement select
	localparam logic [1:0] MEAS_PER_FALL = 2'h0;
	localparam logic [1:0] MEAS_PER_RISE = 2'h1;
	localparam logic [1:0] MEAS_WIDTH    = 2'h2;

	// Divider step, zero and terminal counts
	localparam logic [4:0] DIV_ONE    = 5'h01;
	localparam logic [4:0] DIV8_LAST  = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1f;
	localparam logic [4:0] DIV_ZERO   = 5'h00;

	typedef enum logic [2:0] {
		ST_HALT,
		ST_COUNT,
		ST_RELOAD,
		ST_ARM,
		ST_MEAS
	} ptm_state_t;

endpackage

// >>> hw/ptm_tick_gen.sv
// Purpose: Count source tick generator, main clock and secondary clock dividers
// Assumes: sub_clk is a slow level synchronous to core_clk
// Notes: Tick is registered; a one-cycle pulse except for main clock /1, where it stays high
`timescale 1ns/1ps
`default_nettype none
module ptm_tick_gen (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] src_sel,
	input  wire logic       sub_clk,
	output logic            tick
);

	typedef struct packed {
		logic [4:0] div_cnt;
		logic [4:0] sub_cnt;
		logic       sub_prev;
		logic       tick;
	} ptm_tick_state_t;

	ptm_tick_state_t s_r;
	ptm_tick_state_t s_nxt;

	logic main_clock_div1;
	logic main_clock_div8;
	logic main_clock_div32;
	logic sub_clock_div32;
	logic sub_rise;

	always_comb begin
		s_nxt            = s_r;
		sub_rise         = sub_clk & ~s_r.sub_prev;
		main_clock_div1  = 1'b1;
		main_clock_div8  = (s_r.div_cnt[2:0] == ptm_pkg::DIV8_LAST[2:0]);
		main_clock_div32 = (s_r.div_cnt == ptm_pkg::DIV32_LAST);
		sub_clock_div32  = sub_rise && (s_r.sub_cnt == ptm_pkg::DIV32_LAST);
		s_nxt.div_cnt    = s_r.div_cnt + ptm_pkg::DIV_ONE;
		s_nxt.sub_prev   = sub_clk;
		if (sub_rise) begin
			s_nxt.sub_cnt = s_r.sub_cnt + ptm_pkg::DIV_ONE;
		end
		unique case (src_sel)
			ptm_pkg::SRC_DIV1:  s_nxt.tick = main_clock_div1;
			ptm_pkg::SRC_DIV8:  s_nxt.tick = main_clock_div8;
			ptm_pkg::SRC_DIV32: s_nxt.tick = main_clock_div32;
			ptm_pkg::SRC_SUB32: s_nxt.tick = sub_clock_div32;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

endmodule
`default_nettype wire

// >>> hw/ptm_channel.sv
// Purpose: One 16-bit timer channel with timer, event and measurement modes
// Assumes: All inputs synchronous to core_clk; strobes are one-cycle pulses
// Notes: Neighbour wrap (channel 0 from 2, channel 3 from 5) is wired outside
// Function
// - One 16-bit counter per channel in timer, event or measurement mode.
// - Internal source is main clock /1, /8, /32 or secondary clock /32.
// - Timer and event modes underflow after value plus one ticks, then request.
// - Timer or event read returns the live count as a 16-bit word.
// - Measurement read returns last result; undefined before second edge.
// - Write while counting updates reload only; while stopped, reload and counter.
// - Timer register writes are ignored in measurement mode.
// - Timer mode decrements per tick; underflow reloads, continues, sets request.
// - Clearing the start flag freezes the counter in timer and event modes.
// - Event source is pin falling, rising, both edges or neighbour overflow.
// - Event mode underflow reloads, keeps counting and sets request.
// - Period measurement counts internal source between like edges of the pin.
// - First effective edge clears counter, loads undefined reload, no request.
// - Later edges capture counter into reload, set request, clear counter.
// - Width measurement uses both edges, high and low widths alternate.
// - Measurement request on edge or overflow; overflow flag tells them apart.
// - Overflow flag clears on mode write while started; software never sets it.
// - Overflow flag reads one after reset.
// - Overflow may occur between count start and the first edge.
// - Changing measurement select after start sets request; same value does not.
// - Read at reload instant gives all ones; halted write reads back.
// - Start flag is zero after reset; load the timer before starting.
`timescale 1ns/1ps
`default_nettype none
module ptm_channel (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        timer_input_pin,
	input  wire logic        neighbour_channel,
	input  wire logic        sub_clk,
	input  wire logic        start_wr,
	input  wire logic        start_wdata,
	input  wire logic        mode_wr,
	input  wire logic [1:0]  mode_sel,
	input  wire logic [1:0]  src_sel,
	input  wire logic [1:0]  evt_sel,
	input  wire logic [1:0]  meas_sel,
	input  wire logic        timer_wr,
	input  wire logic [15:0] timer_wdata,
	input  wire logic        timer_rd,
	input  wire logic        irq_clr,
	output logic [15:0]      timer_rdata,
	output logic             irq_req,
	output logic             ovf_flag,
	output logic             count_start,
	output logic             underflow_out
);

	typedef struct packed {
		ptm_pkg::ptm_state_t st;
		logic [15:0]         cnt;
		logic [15:0]         reload;
		logic [15:0]         rdata;
		logic [1:0]          mode;
		logic [1:0]          src;
		logic [1:0]          evt;
		logic [1:0]          meas;
		logic                start;
		logic                irq;
		logic                ovf;
		logic                uflow;
		logic                pin_prev;
	} ptm_chan_state_t;

	localparam ptm_chan_state_t RST_STATE = '{
		st:       ptm_pkg::ST_HALT,
		cnt:      ptm_pkg::RST_CNT,
		reload:   ptm_pkg::RST_RELOAD,
		rdata:    ptm_pkg::RST_CNT,
		mode:     ptm_pkg::MODE_TIMER,
		src:      ptm_pkg::SRC_DIV1,
		evt:      ptm_pkg::EVT_FALL,
		meas:     ptm_pkg::MEAS_PER_FALL,
		start:    ptm_pkg::RST_START,
		irq:      1'b0,
		ovf:      ptm_pkg::RST_OVF,
		uflow:    1'b0,
		// Matches the idle high pin so no false edge follows reset
		pin_prev: 1'b1
	};

	logic [1:0]      rst_sync_r;
	logic            rst_n;
	ptm_chan_state_t s_r;
	ptm_chan_state_t s_nxt;
	logic            int_tick;
	logic            pin_rise;
	logic            pin_fall;
	logic            evt_tick;
	logic            eff_edge;
	logic            src_tick;
	logic            is_meas;
	logic            ovf_set;

	// Pick an edge event from rise and fall by the wanted polarity
	function automatic logic edge_pick(
		input logic rise,
		input logic fall,
		input logic want_rise,
		input logic want_fall
	);
		edge_pick = (rise & want_rise) | (fall & want_fall);
	endfunction

	// Reset is asserted at once but released only after two clean edges
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_r[1];

	ptm_tick_gen u_tick (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.src_sel  (s_r.src),
		.sub_clk  (sub_clk),
		.tick     (int_tick)
	);

	always_comb begin
		s_nxt    = s_r;
		ovf_set  = 1'b0;
		is_meas  = (s_r.mode == ptm_pkg::MODE_MEAS);
		pin_rise = timer_input_pin & ~s_r.pin_prev;
		pin_fall = ~timer_input_pin & s_r.pin_prev;

		unique case (s_r.evt)
			ptm_pkg::EVT_FALL:  evt_tick = edge_pick(pin_rise, pin_fall, 1'b0, 1'b1);
			ptm_pkg::EVT_RISE:  evt_tick = edge_pick(pin_rise, pin_fall, 1'b1, 1'b0);
			ptm_pkg::EVT_BOTH:  evt_tick = edge_pick(pin_rise, pin_fall, 1'b1, 1'b1);
			ptm_pkg::EVT_NEIGH: evt_tick = neighbour_channel;
		endcase

		case (s_r.meas)
			ptm_pkg::MEAS_PER_FALL: eff_edge = edge_pick(pin_rise, pin_fall, 1'b0, 1'b1);
			ptm_pkg::MEAS_PER_RISE: eff_edge = edge_pick(pin_rise, pin_fall, 1'b1, 1'b0);
			// Select code 3 is not a documented choice; treat it as width
			default:                eff_edge = edge_pick(pin_rise, pin_fall, 1'b1, 1'b1);
		endcase

		// Event mode counts pin edges or neighbour overflows, else the divider
		src_tick = (s_r.mode == ptm_pkg::MODE_EVENT) ? evt_tick : int_tick;

		s_nxt.pin_prev = timer_input_pin;
		s_nxt.uflow    = 1'b0;

		// Clears come first so that any set later in this process wins
		if (irq_clr) begin
			s_nxt.irq = 1'b0;
		end

		if (start_wr) begin
			s_nxt.start = start_wdata;
		end

		if (mode_wr) begin
			s_nxt.mode = mode_sel;
			s_nxt.src  = src_sel;
			s_nxt.evt  = evt_sel;
			s_nxt.meas = meas_sel;
			if (s_r.start) begin
				s_nxt.ovf = 1'b0;
				if (is_meas && (meas_sel != s_r.meas)) begin
					s_nxt.irq = 1'b1;
				end
			end
		end

		if (timer_rd) begin
			s_nxt.rdata = is_meas ? s_r.reload : s_r.cnt;
		end

		if (timer_wr && !is_meas) begin
			s_nxt.reload = timer_wdata;
			if (!s_r.start) begin
				s_nxt.cnt = timer_wdata;
			end
		end

		unique case (s_r.st)
			ptm_pkg::ST_HALT: begin
				// Counter holds here; only a halted write moves it
				if (s_r.start) begin
					s_nxt.st = is_meas ? ptm_pkg::ST_ARM : ptm_pkg::ST_COUNT;
				end
			end
			ptm_pkg::ST_COUNT: begin
				if (!s_r.start) begin
					s_nxt.st = ptm_pkg::ST_HALT;
				end else if (is_meas) begin
					s_nxt.st = ptm_pkg::ST_ARM;
				end else if (src_tick) begin
					if (s_r.cnt == ptm_pkg::CNT_ZERO) begin
						// One cycle at all ones makes the reload instant visible
						s_nxt.cnt   = ptm_pkg::CNT_MAX;
						s_nxt.st    = ptm_pkg::ST_RELOAD;
						s_nxt.irq   = 1'b1;
						s_nxt.uflow = 1'b1;
					end else begin
						s_nxt.cnt = s_r.cnt - ptm_pkg::CNT_ONE;
					end
				end
			end
			ptm_pkg::ST_RELOAD: begin
				// Take the newest reload, including a write in this cycle
				s_nxt.cnt = s_nxt.reload;
				s_nxt.st  = s_r.start ? ptm_pkg::ST_COUNT : ptm_pkg::ST_HALT;
			end
			ptm_pkg::ST_ARM,
			ptm_pkg::ST_MEAS: begin
				if (!s_r.start) begin
					s_nxt.st = ptm_pkg::ST_HALT;
				end else if (!is_meas) begin
					s_nxt.st = ptm_pkg::ST_COUNT;
				end else begin
					if (int_tick) begin
						s_nxt.cnt = s_r.cnt + ptm_pkg::CNT_ONE;
						if (s_r.cnt == ptm_pkg::CNT_MAX) begin
							ovf_set   = 1'b1;
							s_nxt.ovf = 1'b1;
							s_nxt.irq = 1'b1;
						end
					end
					// An edge beats a coincident tick; the interval restarts at zero
					if (eff_edge) begin
						s_nxt.cnt    = ptm_pkg::CNT_ZERO;
						s_nxt.reload = s_r.cnt;
						if (s_r.st == ptm_pkg::ST_ARM) begin
							s_nxt.st = ptm_pkg::ST_MEAS;
						end else begin
							s_nxt.irq = 1'b1;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= RST_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign timer_rdata   = s_r.rdata;
	assign irq_req       = s_r.irq;
	assign ovf_flag      = s_r.ovf;
	assign count_start   = s_r.start;
	assign underflow_out = s_r.uflow;

	chk_halt_freeze: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(s_r.st == ptm_pkg::ST_HALT && !timer_wr) |=> (s_r.cnt == $past(s_r.cnt))
	) else $error("counter moved while halted");

	chk_uflow_request: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		s_r.uflow |-> (s_r.irq && s_r.cnt == ptm_pkg::CNT_MAX
			&& s_r.st == ptm_pkg::ST_RELOAD)
	) else $error("underflow without request or all ones");

	chk_uflow_single: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		s_r.uflow |=> !s_r.uflow
	) else $error("underflow pulse longer than one cycle");

	chk_stop_freeze: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(s_r.st == ptm_pkg::ST_COUNT && !s_r.start && !timer_wr)
		|=> (s_r.st == ptm_pkg::ST_HALT && s_r.cnt == $past(s_r.cnt))
	) else $error("clearing start did not freeze the counter");

	chk_reload_after: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(s_r.st == ptm_pkg::ST_RELOAD && !timer_wr)
		|=> (s_r.cnt == $past(s_r.reload))
	) else $error("counter not reloaded after underflow");

	chk_meas_nowrite: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(is_meas && timer_wr && !eff_edge) |=> (s_r.reload == $past(s_r.reload))
	) else $error("timer write took effect in measurement mode");

	chk_run_write: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!is_meas && timer_wr && s_r.start && s_r.st == ptm_pkg::ST_COUNT && !src_tick)
		|=> (s_r.cnt == $past(s_r.cnt) && s_r.reload == $past(timer_wdata))
	) else $error("running write disturbed the counter");

	chk_halt_readback: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!is_meas && timer_wr && !s_r.start && s_r.st == ptm_pkg::ST_HALT && !start_wr)
		##1 timer_rd |=> (s_r.rdata == $past(timer_wdata, 2))
	) else $error("halted write not read back");

	chk_ovf_clear: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(mode_wr && s_r.start && !ovf_set) |=> !s_r.ovf
	) else $error("overflow flag not cleared by mode write");

	chk_ovf_cause: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(s_r.ovf) |-> ($past(ovf_set) && s_r.irq)
	) else $error("overflow flag set without a wrap");

	chk_first_edge: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(s_r.st == ptm_pkg::ST_ARM && s_r.start && is_meas && eff_edge)
		|=> (s_r.cnt == ptm_pkg::CNT_ZERO && s_r.st == ptm_pkg::ST_MEAS)
	) else $error("first edge did not arm measurement");

	chk_edge_capture: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(s_r.st == ptm_pkg::ST_MEAS && s_r.start && is_meas && eff_edge)
		|=> (s_r.reload == $past(s_r.cnt) && s_r.irq && s_r.cnt == ptm_pkg::CNT_ZERO)
	) else $error("measurement not captured on edge");

	chk_meas_change: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(mode_wr && s_r.start && is_meas && meas_sel != s_r.meas) |=> s_r.irq
	) else $error("measurement select change gave no request");

	chk_read_live: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(timer_rd && !is_meas) |=> (s_r.rdata == $past(s_r.cnt))
	) else $error("read did not return the live count");

	chk_read_result: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(timer_rd && is_meas) |=> (s_r.rdata == $past(s_r.reload))
	) else $error("read did not return the measurement");

endmodule
`default_nettype wire

// >>> sim/ptm_pulse_src.sv
// Purpose: Far side model, drives the measured pin and neighbour overflow
// Assumes: Tasks are entered just after a falling edge of core_clk
// Notes: Pin idles high, so a first falling edge needs an explicit low segment
`timescale 1ns/1ps
`default_nettype none
module ptm_pulse_src (
	input  wire logic core_clk,
	output logic      timer_input_pin,
	output logic      neighbour_channel
);
	initial begin
		timer_input_pin = 1'b1;
		neighbour_channel = 1'b0;
	end
	// Level held for n cycles; repeated calls with one level merge into one segment
	task automatic hold(input logic v, input int n);
		timer_input_pin = v;
		repeat (n) @(negedge core_clk);
	endtask
	// One-cycle overflow pulse of the neighbour channel
	task automatic nb_pulse();
		neighbour_channel = 1'b1;
		@(negedge core_clk);
		neighbour_channel = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_ptm_channel.sv
// Purpose: Self-checking bench for the pulse measure timer channel
// Assumes: Inputs change on the falling edge; reads compared by a monitor
// Notes: Overflow scenario runs a full 16-bit wrap, the bulk of the run
`timescale 1ns/1ps
`default_nettype none
module tb_ptm_channel;
	logic        core_clk, resetn, sub_clk, start_wr, start_wdata, mode_wr;
	logic        timer_wr, timer_rd, irq_clr, rd_seen;
	logic [1:0]  mode_sel, src_sel, evt_sel, meas_sel;
	logic [15:0] timer_wdata, timer_rdata;
	logic        irq_req, ovf_flag, count_start, underflow_out, pin, nb;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h1b23fc95;
	int          err_count = 0;
	int          checks = 0;
	ptm_pulse_src ptm_pulse_src_inst (.core_clk(core_clk), .timer_input_pin(pin),
		.neighbour_channel(nb));
	ptm_channel ptm_channel_inst (.core_clk(core_clk), .resetn(resetn),
		.timer_input_pin(pin), .neighbour_channel(nb), .sub_clk(sub_clk),
		.start_wr(start_wr), .start_wdata(start_wdata), .mode_wr(mode_wr),
		.mode_sel(mode_sel), .src_sel(src_sel), .evt_sel(evt_sel), .meas_sel(meas_sel),
		.timer_wr(timer_wr), .timer_wdata(timer_wdata), .timer_rd(timer_rd),
		.irq_clr(irq_clr), .timer_rdata(timer_rdata), .irq_req(irq_req),
		.ovf_flag(ovf_flag), .count_start(count_start), .underflow_out(underflow_out));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Secondary clock: rising edge every 4 core cycles
	initial begin
		sub_clk = 1'b0;
		forever begin
			repeat (2) @(negedge core_clk);
			sub_clk = ~sub_clk;
		end
	end
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task automatic conclude();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic setmode(input logic [1:0] m, input logic [1:0] s, input logic [1:0] e,
		input logic [1:0] ms);
		mode_sel = m;
		src_sel = s;
		evt_sel = e;
		meas_sel = ms;
		mode_wr = 1'b1;
		cyc(1);
		mode_wr = 1'b0;
	endtask
	task automatic start(input logic v);
		start_wdata = v;
		start_wr = 1'b1;
		cyc(1);
		start_wr = 1'b0;
	endtask
	task automatic twr(input logic [15:0] d);
		timer_wdata = d;
		timer_wr = 1'b1;
		cyc(1);
		timer_wr = 1'b0;
	endtask
	task automatic clr();
		irq_clr = 1'b1;
		cyc(1);
		irq_clr = 1'b0;
	endtask
	// Expected read value is queued; the monitor compares when data arrives
	task automatic rd(input logic [15:0] e);
		exp_q.push_back(e);
		timer_rd = 1'b1;
		cyc(1);
		timer_rd = 1'b0;
		cyc(1);
	endtask
	// Cycles until the next underflow pulse, bounded
	task automatic wuf(output int k);
		k = 0;
		while (underflow_out !== 1'b1 && k < 5000) begin
			cyc(1);
			k++;
		end
		if (k == 5000) begin
			$display("ERROR underflow_out expected pulse seen none");
			err_count++;
		end
	endtask
	always @(posedge core_clk) begin
		if (rd_seen && exp_q.size() > 0) begin
			chk("timer_rdata", exp_q.pop_front(), timer_rdata);
		end
		rd_seen <= timer_rd;
	end
	initial begin
		#450_000;
		err_count++;
		conclude();
	end
	initial begin
		int k;
		int dv[4];
		logic [15:0] n;
		dv = '{1, 8, 32, 128};
		{resetn, start_wr, start_wdata, mode_wr, timer_wr, timer_rd, irq_clr} = '0;
		{mode_sel, src_sel, evt_sel, meas_sel, timer_wdata} = '0;
		rd_seen = 1'b0;
		cyc(12);
		resetn = 1'b1;
		cyc(4);
		chk("count_start", 16'h0000, 16'(count_start));
		chk("ovf_flag", 16'h0001, 16'(ovf_flag));
		chk("irq_req", 16'h0000, 16'(irq_req));
		for (int i = 0; i < 4; i++) begin
			n = (rnd() & 16'h0007) + 16'h0001;
			setmode(ptm_pkg::MODE_TIMER, 2'(i), ptm_pkg::EVT_FALL, ptm_pkg::MEAS_PER_FALL);
			twr(n);
			rd(n);
			start(1'b1);
			wuf(k);
			cyc(1);
			wuf(k);
			chk("period", 16'(i == 0 ? n + 2 : (n + 1) * dv[i]), 16'(k + 1));
			chk("irq_req", 16'h0001, 16'(irq_req));
			twr(n + 16'h0002);
			cyc(1);
			wuf(k);
			cyc(1);
			wuf(k);
			chk("period", 16'(i == 0 ? n + 4 : (n + 3) * dv[i]), 16'(k + 1));
			start(1'b0);
			clr();
			twr(n);
			rd(n);
			cyc(20);
			rd(n);
		end
		// Each event source counts one pulse; both-edge mode sees two events
		for (int i = 0; i < 4; i++) begin
			setmode(ptm_pkg::MODE_EVENT, ptm_pkg::SRC_DIV1, 2'(i), ptm_pkg::MEAS_PER_FALL);
			twr(16'h0003);
			start(1'b1);
			cyc(2);
			if (i == 3) begin
				ptm_pulse_src_inst.nb_pulse();
			end else begin
				ptm_pulse_src_inst.hold(1'b0, 4);
				ptm_pulse_src_inst.hold(1'b1, 4);
			end
			cyc(4);
			rd(i == 2 ? 16'h0001 : 16'h0002);
			start(1'b0);
		end
		twr(16'h0001);
		start(1'b1);
		cyc(2);
		repeat (2) begin
			ptm_pulse_src_inst.nb_pulse();
			cyc(2);
		end
		cyc(2);
		chk("irq_req", 16'h0001, 16'(irq_req));
		rd(16'h0001);
		start(1'b0);
		clr();
		setmode(ptm_pkg::MODE_MEAS, ptm_pkg::SRC_DIV1, ptm_pkg::EVT_FALL, ptm_pkg::MEAS_WIDTH);
		start(1'b1);
		setmode(ptm_pkg::MODE_MEAS, ptm_pkg::SRC_DIV1, ptm_pkg::EVT_FALL, ptm_pkg::MEAS_WIDTH);
		cyc(2);
		chk("ovf_flag", 16'h0000, 16'(ovf_flag));
		clr();
		ptm_pulse_src_inst.hold(1'b0, 10);
		chk("irq_req", 16'h0000, 16'(irq_req));
		ptm_pulse_src_inst.hold(1'b1, 6);
		chk("irq_req", 16'h0001, 16'(irq_req));
		rd(16'h0009);
		twr(16'h1234);
		ptm_pulse_src_inst.hold(1'b1, 3);
		ptm_pulse_src_inst.hold(1'b0, 6);
		rd(16'h000b);
		ptm_pulse_src_inst.hold(1'b0, 4);
		ptm_pulse_src_inst.hold(1'b1, 6);
		rd(16'h000b);
		clr();
		setmode(ptm_pkg::MODE_MEAS, ptm_pkg::SRC_DIV1, ptm_pkg::EVT_FALL, ptm_pkg::MEAS_PER_FALL);
		cyc(2);
		chk("irq_req", 16'h0001, 16'(irq_req));
		clr();
		setmode(ptm_pkg::MODE_MEAS, ptm_pkg::SRC_DIV1, ptm_pkg::EVT_FALL, ptm_pkg::MEAS_PER_FALL);
		cyc(2);
		chk("irq_req", 16'h0000, 16'(irq_req));
		repeat (3) begin
			ptm_pulse_src_inst.hold(1'b0, 8);
			ptm_pulse_src_inst.hold(1'b1, 12);
		end
		ptm_pulse_src_inst.hold(1'b0, 6);
		rd(16'h0013);
		ptm_pulse_src_inst.hold(1'b1, 2);
		// Rise to rise interval of ten cycles
		setmode(ptm_pkg::MODE_MEAS, ptm_pkg::SRC_DIV1, ptm_pkg::EVT_FALL, ptm_pkg::MEAS_PER_RISE);
		ptm_pulse_src_inst.hold(1'b0, 4);
		ptm_pulse_src_inst.hold(1'b1, 6);
		ptm_pulse_src_inst.hold(1'b0, 4);
		ptm_pulse_src_inst.hold(1'b1, 2);
		rd(16'h0009);
		clr();
		chk("ovf_flag", 16'h0000, 16'(ovf_flag));
		// No edges for a full wrap of the up-counter
		cyc(65600);
		chk("ovf_flag", 16'h0001, 16'(ovf_flag));
		chk("irq_req", 16'h0001, 16'(irq_req));
		cyc(4);
		conclude();
	end
endmodule
`default_nettype wire
